// File: bench/pir_plant.sv
// Purpose: process side model feeding the regulator's signal inputs
// Assumes: levels in percent x100, set by the bench
// Notes: copies move one clock late, like a sampled sensor chain
`timescale 1ns/1ps
module pir_plant (
  // clock and levels wanted
  input wire logic clk,
  input wire logic [15:0] a1_lvl,
  input wire logic [15:0] a2_lvl,
  input wire logic [15:0] pf_lvl,
  input wire logic [15:0] en_lvl,
  // process signals
  output logic [15:0] ain1,
  output logic [15:0] ain2,
  output logic [15:0] pfb,
  output logic [15:0] enc
);
  // same 1 ns lag as the bench so no edge race
  always @(posedge clk) begin
    ain1 <= #1 a1_lvl;
    ain2 <= #1 a2_lvl;
    pfb <= #1 pf_lvl;
    enc <= #1 en_lvl;
  end
endmodule

// File: bench/testbench.sv
// Purpose: self-checking bench for the process regulator
// Assumes: 0.1 s tick shortened to 10 cycles
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module testbench import pir_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] src = 4'h0;
  logic [1:0] rsel = 2'h0;
  logic [1:0] fsel = 2'h0;
  logic [15:0] sref = 16'h1388;
  logic sload = 1'b0;
  logic pol = 1'b0;
  logic [7:0] gain = 8'h0a;
  logic [7:0] band = 8'h14;
  logic [9:0] itime = 10'h000;
  logic [9:0] per = 10'h001;
  logic [15:0] thr = 16'h000a;
  logic [9:0] ldly = 10'h064;
  logic [15:0] a1 = 16'h0fa0;
  logic [15:0] a2 = 16'h1f40;
  logic [15:0] pf = 16'h0fa0;
  logic [15:0] en = 16'h1770;
  logic [15:0] ain1, ain2, pfb, enc;
  logic act, strb, flt;
  logic signed [31:0] fc, v;
  int error_cnt = 0;
  int check_count = 0;
  int n, m;
  always #2.5 clk = ~clk;
  pir_plant pir_plant_i (.clk(clk), .a1_lvl(a1), .a2_lvl(a2), .pf_lvl(pf), .en_lvl(en),
    .ain1(ain1), .ain2(ain2), .pfb(pfb), .enc(enc));
  pir_top #(.TENTH_DIV(10)) pir_top_i (.REF_CLK(clk), .RST(rst),
    .FREQUENCY_COMMAND_SOURCE(src), .REFERENCE_SOURCE_SELECT(rsel),
    .STORED_REFERENCE_VALUE(sref), .STORED_REFERENCE_LOAD(sload),
    .FEEDBACK_SOURCE_SELECT(fsel), .OUTPUT_POLARITY_SELECT(pol),
    .PROPORTIONAL_GAIN_SETTING(gain), .INTEGRAL_TIME_SETTING(itime),
    .DEVIATION_BAND_LIMIT(band), .SAMPLE_PERIOD_SETTING(per),
    .FEEDBACK_LOSS_THRESHOLD(thr), .FEEDBACK_LOSS_DELAY(ldly),
    .KEYPAD_ENCODER_VALUE(enc), .ANALOG_INPUT_ONE(ain1), .ANALOG_INPUT_TWO(ain2),
    .PULSE_FEEDBACK(pfb), .REGULATOR_ACTIVE(act), .FREQ_CORRECTION(fc),
    .SAMPLE_STROBE(strb), .FEEDBACK_LOSS_FAULT(flt));
  // ************
  // helper tasks
  // ************
  task chk(input logic signed [31:0] s, input logic signed [31:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t seen %0d expected %0d", $time, s, e);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // bounded wait: a stuck strobe must not hang the run
  task stb();
    for (int i = 0; i < 200; i++) begin
      cyc(1);
      if (strb === 1'b1) return;
    end
    error_cnt++;
    $display("[FAIL] %0t no sample strobe", $time);
  endtask
  // two samples so the first may still use old settings
  task run2();
    stb();
    stb();
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ***********
  // test flow
  // ***********
  initial begin
    cyc(10);
    rst = 1'b0;
    chk(flt, 0);
    run2();
    chk(fc, 0);
    chk(act, 0);
    src = FREQ_SRC_PI;
    run2();
    chk(act, 1);
    chk(fc, -32'sh0fa0);
    sref = 16'hffff;
    sload = 1'b1;
    cyc(1);
    sload = 1'b0;
    run2();
    chk(fc, 32'sh1770);
    sref = 16'h1388;
    sload = 1'b1;
    cyc(1);
    sload = 1'b0;
    run2();
    chk(fc, 32'sh03e8);
    pol = 1'b1;
    run2();
    chk(fc, -32'sh03e8);
    pol = 1'b0;
    gain = 8'h14;
    run2();
    chk(fc, 32'sh07d0);
    $display("test polarity and gain done");
    gain = 8'h0a;
    fsel = 2'h2;
    a1 = 16'h1b58;
    for (n = 1; n < 4; n++) begin
      rsel = n[1:0];
      run2();
      chk(fc, 32'sh03e8 * (n + 1));
    end
    // gain above 10.0 acts as 10.0; small error keeps the output off its limit
    gain = 8'hff;
    pf = 16'h1e14;
    run2();
    chk(fc, 32'sh0bb8);
    pf = 16'h0fa0;
    run2();
    chk(fc, 32'sh2710);
    gain = 8'h0a;
    rsel = 2'h0;
    fsel = 2'h1;
    run2();
    chk(fc, -32'sh0bb8);
    fsel = 2'h0;
    a1 = 16'h1324;
    run2();
    chk(fc, -32'sh0bb8);
    band = 8'h00;
    run2();
    chk(fc, 32'sh0064);
    $display("test sources and band done");
    a1 = 16'h0fa0;
    itime = 10'h00a;
    run2();
    v = fc;
    stb();
    chk(fc, v + 32'sh0064);
    itime = 10'h005;
    run2();
    v = fc;
    stb();
    chk(fc, v + 32'sh00c8);
    itime = 10'h000;
    for (n = 1; n < 3; n++) begin
      per = n[9:0];
      run2();
      m = 0;
      do begin
        cyc(1);
        m++;
      end while (strb !== 1'b1 && m < 100);
      chk(m, 10 * n);
    end
    $display("test integral and period done");
    thr = 16'h0064;
    ldly = 10'h003;
    a1 = 16'h0032;
    cyc(25);
    chk(flt, 0);
    a1 = 16'h0fa0;
    cyc(5);
    a1 = 16'h0032;
    cyc(25);
    chk(flt, 0);
    cyc(20);
    chk(flt, 1);
    a1 = 16'h0fa0;
    cyc(5);
    chk(flt, 1);
    rst = 1'b1;
    cyc(1);
    rst = 1'b0;
    chk(flt, 0);
    $display("test feedback loss done");
    end_sim();
  end
  initial begin
    #100000;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end
endmodule

// File: hdl/pir_pkg.sv
// Purpose: constants for the process regulator
// Assumes: percent values scaled x100 (0..10000), gain x10, times in 0.1 s units
// Notes:
// Operation
// - regulator drives frequency only when command source selects closed loop
// - reference source code: 0 keypad, 1 encoder, 2 analog one, 3 analog two
// - keypad source uses stored reference 0.00 to 100.00 percent, default 0.00
// - feedback comes from a source chosen by its own selector
// - polarity 0: feedback above reference lowers frequency
// - polarity 1: feedback above reference raises frequency
// - proportional gain 0.0 to 10.0, default 1.0
// - integral time 0.0 to 100.0 s, default 1.0 s; shorter is stronger
// - proportional term is gain times present deviation
// - integral keeps accumulating deviation each step while deviation remains
// - regulation suspended while deviation magnitude within band, default 2.0
// - sample and compute once per sampling period, 0.1 to 100.0 s, default 0.2 s
// - feedback below loss threshold, 0.1 to 50.0 percent, counts as disconnected
// - disconnection longer than delay, default 10.0 s, raises loss fault
package pir_pkg;
  localparam int CLK_HZ = 200000000;
  localparam int TENTH_S_NS = 100000000;
  localparam int CLK_NS = 5;
  localparam int TENTH_CYC = TENTH_S_NS / CLK_NS;
  localparam logic [1:0] REF_KEYPAD = 2'h0;
  localparam logic [1:0] REF_ENCODER = 2'h1;
  localparam logic [1:0] REF_AIN1 = 2'h2;
  localparam logic [1:0] REF_AIN2 = 2'h3;
  localparam logic [15:0] STORED_REF_RST = 16'h0000;
  localparam logic [15:0] PCT_MAX = 16'h2710;
  localparam logic [7:0] GAIN_RST = 8'h0a;
  localparam logic [7:0] GAIN_MAX = 8'h64;
  localparam logic [9:0] ITIME_RST = 10'h00a;
  localparam logic [9:0] TIME_MAX = 10'h3e8;
  localparam logic [7:0] BAND_RST = 8'h14;
  localparam logic [7:0] BAND_MAX = 8'hc8;
  localparam logic [9:0] SAMPLE_RST = 10'h002;
  localparam logic [9:0] SAMPLE_MIN = 10'h001;
  localparam logic [15:0] LOSS_THR_RST = 16'h000a;
  localparam logic [15:0] LOSS_THR_MIN = 16'h000a;
  localparam logic [15:0] LOSS_THR_MAX = 16'h1388;
  localparam logic [9:0] LOSS_DLY_RST = 10'h064;
  localparam logic [9:0] LOSS_DLY_MIN = 10'h001;
  localparam logic [3:0] FREQ_SRC_PI = 4'h5;
  localparam logic signed [31:0] OUT_MAX = 32'sh00002710;
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
  function automatic logic [9:0] clamp10(input logic [9:0] v, input logic [9:0] lo,
                                         input logic [9:0] hi);
    clamp10 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
endpackage

// File: hdl/pir_tick.sv
// Purpose: 0.1 s tick divider
// Assumes: 200 MHz clock
// Notes: DIV (default TENTH_CYC) is a parameter so simulation can shorten it
`timescale 1ns/1ps
module pir_tick import pir_pkg::*; #(
  parameter int DIV = TENTH_CYC
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } pir_tick_t;
  pir_tick_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt >= 32'(DIV - 1)) begin
      s_d.cnt = 32'h0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick = s_q.tick;
endmodule

// File: hdl/pir_top.sv
// Purpose: proportional-integral process regulator
// Assumes: all settings are static-ish levels, synchronous to REF_CLK
// Notes: output is a signed frequency correction, scaled as percent x100
`timescale 1ns/1ps
module pir_top import pir_pkg::*; #(
  parameter int TENTH_DIV = TENTH_CYC
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // settings
  input wire logic [3:0] FREQUENCY_COMMAND_SOURCE,
  input wire logic [1:0] REFERENCE_SOURCE_SELECT,
  input wire logic [15:0] STORED_REFERENCE_VALUE,
  input wire logic STORED_REFERENCE_LOAD,
  input wire logic [1:0] FEEDBACK_SOURCE_SELECT,
  input wire logic OUTPUT_POLARITY_SELECT,
  input wire logic [7:0] PROPORTIONAL_GAIN_SETTING,
  input wire logic [9:0] INTEGRAL_TIME_SETTING,
  input wire logic [7:0] DEVIATION_BAND_LIMIT,
  input wire logic [9:0] SAMPLE_PERIOD_SETTING,
  input wire logic [15:0] FEEDBACK_LOSS_THRESHOLD,
  input wire logic [9:0] FEEDBACK_LOSS_DELAY,
  // process signals, percent x100
  input wire logic [15:0] KEYPAD_ENCODER_VALUE,
  input wire logic [15:0] ANALOG_INPUT_ONE,
  input wire logic [15:0] ANALOG_INPUT_TWO,
  input wire logic [15:0] PULSE_FEEDBACK,
  // results
  output logic REGULATOR_ACTIVE,
  output logic signed [31:0] FREQ_CORRECTION,
  output logic SAMPLE_STROBE,
  output logic FEEDBACK_LOSS_FAULT
);
  typedef struct packed {
    logic [15:0] stored_ref;
    logic [9:0] per_cnt;
    logic [9:0] loss_cnt;
    logic [31:0] div_cnt;
    logic signed [47:0] integ;
    logic signed [31:0] out;
    logic strobe;
    logic active;
    logic fault;
  } pir_state_t;

  pir_state_t s_q, s_d;
  logic tick;
  logic [15:0] ref_v, fb_v;
  logic signed [17:0] dev;
  logic [17:0] dev_mag;
  logic signed [47:0] integ_step;
  logic signed [47:0] p_term;
  logic signed [47:0] sum;
  logic [9:0] per_lim, itime, loss_lim;
  logic sample_now;
  logic [7:0] gain_c;
  logic signed [47:0] integ_nx;
  logic in_band;
  logic fb_low;
  // accumulator ceiling, far above any value that can still reach the output
  localparam logic signed [47:0] INTEG_LIM = 48'sh010000000000;

  pir_tick #(.DIV(TENTH_DIV)) u_tick (
    .clk(REF_CLK),
    .rst(RST),
    .tick(tick)
  );

  // ************************************************************
  // source selection and arithmetic
  // ************************************************************
  always_comb begin
    case (REFERENCE_SOURCE_SELECT)
      REF_KEYPAD: ref_v = s_q.stored_ref;
      REF_ENCODER: ref_v = KEYPAD_ENCODER_VALUE;
      REF_AIN1: ref_v = ANALOG_INPUT_ONE;
      default: ref_v = ANALOG_INPUT_TWO;
    endcase
    case (FEEDBACK_SOURCE_SELECT)
      2'h0: fb_v = ANALOG_INPUT_ONE;
      2'h1: fb_v = ANALOG_INPUT_TWO;
      default: fb_v = PULSE_FEEDBACK;
    endcase
    // error signed so that positive means frequency should rise
    if (OUTPUT_POLARITY_SELECT) begin
      dev = $signed({2'b00, fb_v}) - $signed({2'b00, ref_v});
    end else begin
      dev = $signed({2'b00, ref_v}) - $signed({2'b00, fb_v});
    end
    dev_mag = dev[17] ? 18'(-dev) : 18'(dev);
    per_lim = clamp10(SAMPLE_PERIOD_SETTING, SAMPLE_MIN, TIME_MAX);
    itime = clamp10(INTEGRAL_TIME_SETTING, 10'h000, TIME_MAX);
    loss_lim = clamp10(FEEDBACK_LOSS_DELAY, LOSS_DLY_MIN, TIME_MAX);
    // gain x10: p = dev*gain/10; every operand signed, else a negative error wraps
    gain_c = (PROPORTIONAL_GAIN_SETTING > GAIN_MAX) ? GAIN_MAX :
             PROPORTIONAL_GAIN_SETTING;
    p_term = $signed(48'(dev)) * $signed(48'(gain_c)) / 48'sd10;
    // integral step = dev*gain*period/(10*itime); zero itime disables integral
    if (itime == 10'h000) begin
      integ_step = '0;
    end else begin
      integ_step = $signed(48'(dev)) * $signed(48'(gain_c)) * $signed(48'(per_lim))
                   / (48'sd10 * $signed(48'(itime)));
    end
    // saturate rather than let a long-standing error wrap the accumulator
    integ_nx = s_q.integ + integ_step;
    if (integ_nx > INTEG_LIM) begin
      integ_nx = INTEG_LIM;
    end else if (integ_nx < -INTEG_LIM) begin
      integ_nx = -INTEG_LIM;
    end
    in_band = (dev_mag <= 18'(DEVIATION_BAND_LIMIT > BAND_MAX ? BAND_MAX :
              DEVIATION_BAND_LIMIT) * 18'd10);
    fb_low = fb_v < clamp16(FEEDBACK_LOSS_THRESHOLD, LOSS_THR_MIN, LOSS_THR_MAX);
  end

  assign sample_now = tick && (s_q.per_cnt + 10'h1 >= per_lim);

  // ************************************************************
  // state update
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.strobe = 1'b0;
    sum = '0;
    if (STORED_REFERENCE_LOAD) begin
      s_d.stored_ref = clamp16(STORED_REFERENCE_VALUE, 16'h0000, PCT_MAX);
    end
    s_d.active = (FREQUENCY_COMMAND_SOURCE == FREQ_SRC_PI);
    if (tick) begin
      s_d.per_cnt = sample_now ? 10'h000 : s_q.per_cnt + 10'h1;
    end
    if (sample_now) begin
      s_d.strobe = 1'b1;
      // dev_mag x100 vs band x10
      if (in_band) begin
        s_d.integ = s_q.integ;
        s_d.out = s_q.out;
      end else begin
        s_d.integ = integ_nx;
        sum = s_d.integ + p_term;
        if (sum > 48'(OUT_MAX)) begin
          s_d.out = OUT_MAX;
        end else if (sum < -48'(OUT_MAX)) begin
          s_d.out = -OUT_MAX;
        end else begin
          s_d.out = 32'(sum);
        end
      end
    end
    if (!s_d.active) begin
      s_d.integ = '0;
      s_d.out = '0;
    end
    // loss detection runs continuously
    if (fb_low) begin
      if (tick && !s_q.fault) begin
        if (s_q.loss_cnt >= loss_lim) begin
          s_d.fault = 1'b1;
        end else begin
          s_d.loss_cnt = s_q.loss_cnt + 10'h1;
        end
      end
    end else begin
      s_d.loss_cnt = 10'h000;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      s_q <= '{stored_ref: STORED_REF_RST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign REGULATOR_ACTIVE = s_q.active;
  assign FREQ_CORRECTION = s_q.out;
  assign SAMPLE_STROBE = s_q.strobe;
  assign FEEDBACK_LOSS_FAULT = s_q.fault;

  // ************************************************************
  // checks
  // ************************************************************
  a_inactive_zero: assert property (@(posedge REF_CLK) disable iff (RST)
    !REGULATOR_ACTIVE |-> FREQ_CORRECTION == 0) else $error("output while inactive");
  a_hold_between: assert property (@(posedge REF_CLK) disable iff (RST)
    !SAMPLE_STROBE && $past(REGULATOR_ACTIVE) && REGULATOR_ACTIVE |-> $stable(FREQ_CORRECTION))
    else $error("output moved off sample");
  a_loss_clear: assert property (@(posedge REF_CLK) disable iff (RST)
    fb_v >= clamp16(FEEDBACK_LOSS_THRESHOLD, LOSS_THR_MIN, LOSS_THR_MAX) |=> s_q.loss_cnt == 0)
    else $error("loss timer not cleared");
  a_fault_sticky: assert property (@(posedge REF_CLK) disable iff (RST)
    FEEDBACK_LOSS_FAULT |=> FEEDBACK_LOSS_FAULT) else $error("fault dropped");
  a_band_hold: assert property (@(posedge REF_CLK) disable iff (RST)
    sample_now && s_d.active && s_q.active && dev_mag <= 18'(DEVIATION_BAND_LIMIT) * 18'd10
    && DEVIATION_BAND_LIMIT <= BAND_MAX |=> $stable(s_q.integ)) else $error("band not held");
  a_keypad_ref: assert property (@(posedge REF_CLK) disable iff (RST)
    REFERENCE_SOURCE_SELECT == REF_KEYPAD |-> ref_v == s_q.stored_ref)
    else $error("keypad ref wrong");
  a_ref_range: assert property (@(posedge REF_CLK) disable iff (RST)
    s_q.stored_ref <= PCT_MAX) else $error("stored ref out of range");
  a_strobe_single: assert property (@(posedge REF_CLK) disable iff (RST)
    SAMPLE_STROBE |=> !SAMPLE_STROBE) else $error("double sample");
  a_pos_polarity: assert property (@(posedge REF_CLK) disable iff (RST)
    !OUTPUT_POLARITY_SELECT && fb_v > ref_v |-> dev < 0) else $error("polarity wrong");
  a_neg_polarity: assert property (@(posedge REF_CLK) disable iff (RST)
    OUTPUT_POLARITY_SELECT && fb_v > ref_v |-> dev > 0) else $error("polarity wrong");

  // regulation step: an active sample outside the band adds integ_step to the accumulator, saturating at INTEG_LIM
  sequence s_regulate;
    sample_now && s_d.active && !in_band;
  endsequence
  sequence s_integ_moved;
    SAMPLE_STROBE && s_q.integ != $past(s_q.integ);
  endsequence
  // loss timer has run out while feedback is still low
  sequence s_loss_expire;
    tick && fb_low && !FEEDBACK_LOSS_FAULT && s_q.loss_cnt >= loss_lim;
  endsequence
  a_integ_moves: assert property (@(posedge REF_CLK) disable iff (RST)
    s_regulate ##0 (integ_step != 0 && s_q.integ < INTEG_LIM && s_q.integ > -INTEG_LIM)
    |=> s_integ_moved) else $error("integral did not move");
  a_loss_raise: assert property (@(posedge REF_CLK) disable iff (RST)
    s_loss_expire |=> FEEDBACK_LOSS_FAULT) else $error("loss fault not raised");
  a_loss_early: assert property (@(posedge REF_CLK) disable iff (RST)
    !FEEDBACK_LOSS_FAULT && !(tick && fb_low && s_q.loss_cnt >= loss_lim)
    |=> !FEEDBACK_LOSS_FAULT) else $error("loss fault too early");
  a_loss_count: assert property (@(posedge REF_CLK) disable iff (RST)
    tick && fb_low && !FEEDBACK_LOSS_FAULT && s_q.loss_cnt < loss_lim
    |=> s_q.loss_cnt == $past(s_q.loss_cnt) + 10'h1) else $error("loss timer stalled");
  a_strobe_set: assert property (@(posedge REF_CLK) disable iff (RST)
    sample_now |=> SAMPLE_STROBE) else $error("sample strobe missing");
  a_strobe_clear: assert property (@(posedge REF_CLK) disable iff (RST)
    !sample_now |=> !SAMPLE_STROBE) else $error("strobe without sample");
  a_period_bound: assert property (@(posedge REF_CLK) disable iff (RST)
    s_q.per_cnt < TIME_MAX) else $error("period counter overrun");
  a_active_track: assert property (@(posedge REF_CLK) disable iff (RST)
    FREQUENCY_COMMAND_SOURCE == FREQ_SRC_PI |=> REGULATOR_ACTIVE)
    else $error("regulator not engaged");
endmodule
